//--- rtl/dhp_regs.svh
`ifndef DHP_REGS_SVH
`define DHP_REGS_SVH

// Low address codes; the top address line is not decoded
`define DHP_ADDR_WIDTH     3
`define DHP_DATA_WIDTH     16
`define DHP_ADDR_HOLD      2'h0
`define DHP_ADDR_COMMIT    2'h1
`define DHP_ADDR_STATUS    2'h2
`define DHP_ADDR_OUTDATA   2'h3
`define DHP_TARGET_COUNT   4
`define DHP_TARGET_RESET   16'h0000
`define DHP_IRQ_LEN_RESET  8'h04
`define DHP_IRQ_LEN_TARGET 2'h0
`define DHP_PHASE_CYCLES   3'h6

`endif

//--- rtl/dhp_pkg.sv
package dhp_pkg;
	typedef logic [15:0] dhp_word_t;
	typedef enum logic [1:0] {
		DHP_HOST_IDLE,
		DHP_HOST_SETUP,
		DHP_HOST_STROBE,
		DHP_HOST_RELEASE
	} dhp_host_state_t;
endpackage

//--- rtl/dhp_bus_if.sv
`timescale 1ns/10ps
interface dhp_bus_if;
	logic [15:0] data_from_host;
	logic        data_host_oe_n;
	logic [15:0] data_from_dev;
	logic        data_dev_oe_n;
	logic [2:0]  addr;
	logic        chip_sel_n;
	logic        wr_strobe_n;
	logic        rd_strobe_n;
	logic        bus_mode;
	logic        new_output_irq;
	wire  [15:0] data_bus;

	// Resolved bus level from the two enables
	assign data_bus = !data_dev_oe_n ? data_from_dev : (!data_host_oe_n ? data_from_host : 16'hFFFF);

	modport dev (
		input  data_bus,
		output data_from_dev,
		output data_dev_oe_n,
		input  addr,
		input  chip_sel_n,
		input  wr_strobe_n,
		input  rd_strobe_n,
		input  bus_mode,
		output new_output_irq
	);
	modport host (
		input  data_bus,
		output data_from_host,
		output data_host_oe_n,
		output addr,
		output chip_sel_n,
		output wr_strobe_n,
		output rd_strobe_n,
		output bus_mode,
		input  new_output_irq
	);
endinterface

//--- rtl/dhp_sync.sv
`timescale 1ns/10ps
module dhp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_n_in,
	input  wire logic             ce_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage1   <= '0;
			sync_out <= '0;
		end else if (ce_in) begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // dhp_sync

//--- rtl/dhp_device.sv
// Behaviour
// - 16-bit data bus, 3-bit address
// - Top address line ignored, two decoded
// - Mode pin picks bus style, default low
// - Mode low: write on strobe rise, chip selected
// - Write loads holding or commits to target
// - Mode low: read drives while strobe, select low
// - Mode high, direction low: write on strobe rise
// - Mode high, direction high: read while strobe low
// - Host sets direction high read, low write
// - Chip select timed like the address
// - Interrupt pulses programmable cycles on new data
`timescale 1ns/10ps
`include "dhp_regs.svh"
module dhp_device (
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	dhp_bus_if.dev           bus,
	input  wire logic [15:0] chan_data_in,
	input  wire logic        chan_valid_in,
	output logic [15:0]      target0_out,
	output logic [15:0]      target1_out,
	output logic [15:0]      target2_out,
	output logic [15:0]      target3_out
);
	// =========================================================
	// Pin synchronisers
	// =========================================================
	logic [15:0] data_s;
	logic [5:0]  ctl_s;
	logic        mode_s;
	logic        cs_n_s;
	logic        wr_n_s;
	logic        rd_n_s;
	logic [1:0]  addr_s;
	logic        data_strobe_n_prev;

	// Bus words stay steady around each strobe, so per-bit sync is safe
	dhp_sync #(.WIDTH(16)) u_sync_data (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.async_in (bus.data_bus),
		.sync_out (data_s)
	);
	// Top address line not sampled at all
	// Active-low pins stored inverted so reset reads as idle
	dhp_sync #(.WIDTH(6)) u_sync_ctl (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.async_in ({bus.addr[1:0], !bus.chip_sel_n, !bus.wr_strobe_n, !bus.rd_strobe_n, bus.bus_mode}),
		.sync_out (ctl_s)
	);
	assign addr_s = ctl_s[5:4];
	assign cs_n_s = !ctl_s[3];
	assign wr_n_s = !ctl_s[2];
	assign rd_n_s = !ctl_s[1];
	assign mode_s = ctl_s[0];

	// =========================================================
	// Style decode
	// =========================================================
	logic strobe_n;
	logic wr_rise;
	logic rd_active;
	logic mode0_strobe_n;
	logic mode1_dir_write;
	logic mode0_read;
	logic mode1_read;

	// Mode low: write strobe gated by select; mode high: data strobe + direction
	assign mode0_strobe_n  = wr_n_s | cs_n_s;
	assign mode1_dir_write = !rd_n_s;
	assign mode0_read      = !rd_n_s && !cs_n_s;
	assign mode1_read      = !wr_n_s && rd_n_s;
	assign strobe_n        = mode_s ? wr_n_s : mode0_strobe_n;
	assign wr_rise         = strobe_n && !data_strobe_n_prev && (mode_s ? mode1_dir_write : 1'b1);
	assign rd_active       = mode_s ? mode1_read : mode0_read;

	// =========================================================
	// Address decode
	// =========================================================
	logic addr_is_hold;
	logic addr_is_commit;
	logic addr_is_status;
	logic addr_is_outdata;

	logic hold_load;
	logic commit_load;
	logic outdata_read;

	assign addr_is_hold    = (addr_s == `DHP_ADDR_HOLD);
	assign addr_is_commit  = (addr_s == `DHP_ADDR_COMMIT);
	assign addr_is_status  = (addr_s == `DHP_ADDR_STATUS);
	assign addr_is_outdata = (addr_s == `DHP_ADDR_OUTDATA);
	// Writes to status and channel word addresses are dropped
	assign hold_load       = wr_rise && addr_is_hold;
	assign commit_load     = wr_rise && addr_is_commit;
	assign outdata_read    = rd_active && addr_is_outdata;

	// =========================================================
	// Holding and target registers
	// =========================================================
	logic [15:0] hold;
	logic [15:0] target [`DHP_TARGET_COUNT];
	logic [1:0]  target_sel;
	logic [15:0] last_out;
	logic        new_flag;

	assign target_sel = hold[1:0];

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_strobe_n_prev <= 1'b1;
			hold       <= `DHP_TARGET_RESET;
			for (int i = 0; i < `DHP_TARGET_COUNT; i++) begin
				target[i] <= `DHP_TARGET_RESET;
			end
		end else if (ce_in) begin
			data_strobe_n_prev <= strobe_n;
			if (hold_load) begin
				hold <= data_s;
			end
			if (commit_load) begin
				target[data_s[1:0]] <= hold;
			end
		end
	end

	// =========================================================
	// New output data capture and interrupt
	// =========================================================
	logic [7:0] irq_len;
	logic [7:0] irq_cnt;
	logic       irq_busy;
	logic [7:0] next_irq_cnt;
	logic       next_irq;
	logic       flag_set;
	logic       flag_clr;

	// A zero length still gives a one-cycle pulse
	assign irq_len      = (target[`DHP_IRQ_LEN_TARGET][7:0] == 8'h00) ? 8'h01 : target[`DHP_IRQ_LEN_TARGET][7:0];
	assign irq_busy     = (irq_cnt != 8'h00);
	assign next_irq_cnt = chan_valid_in ? irq_len : (irq_busy ? irq_cnt - 8'h01 : 8'h00);
	assign next_irq     = chan_valid_in || (irq_cnt > 8'h01);
	assign flag_set     = chan_valid_in;
	assign flag_clr     = outdata_read;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_out           <= 16'h0000;
			new_flag           <= 1'b0;
			irq_cnt            <= 8'h00;
			bus.new_output_irq <= 1'b0;
		end else if (ce_in) begin
			if (chan_valid_in) begin
				last_out <= chan_data_in;
			end
			irq_cnt            <= next_irq_cnt;
			bus.new_output_irq <= next_irq;
			// Set wins over clear by a read of the data word
			if (flag_set) begin
				new_flag <= 1'b1;
			end else if (flag_clr) begin
				new_flag <= 1'b0;
			end
		end
	end

	// =========================================================
	// Read path
	// =========================================================
	logic [15:0] rd_word;
	logic [15:0] status_word;
	logic [15:0] commit_word;

	// Commit address reads back the target picked by the holding register
	assign status_word = {15'h0000, new_flag};
	assign commit_word = target[target_sel];

	assign rd_word     = addr_is_hold   ? hold :
	                     addr_is_commit ? commit_word :
	                     addr_is_status ? status_word : last_out;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus.data_from_dev <= 16'h0000;
			bus.data_dev_oe_n <= 1'b1;
		end else if (ce_in) begin
			bus.data_from_dev <= rd_word;
			bus.data_dev_oe_n <= !rd_active;
		end
	end

	// Target copies for the outside
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			target0_out <= `DHP_TARGET_RESET;
			target1_out <= `DHP_TARGET_RESET;
			target2_out <= `DHP_TARGET_RESET;
			target3_out <= `DHP_TARGET_RESET;
		end else if (ce_in) begin
			target0_out <= target[0];
			target1_out <= target[1];
			target2_out <= target[2];
			target3_out <= target[3];
		end
	end
endmodule // dhp_device

//--- rtl/dhp_host.sv
`timescale 1ns/10ps
`include "dhp_regs.svh"
module dhp_host (
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	dhp_bus_if.host          bus,
	input  wire logic        mode_in,
	input  wire logic        req_in,
	input  wire logic        req_write_in,
	input  wire logic [1:0]  req_addr_in,
	input  wire logic [15:0] req_data_in,
	output logic             busy_out,
	output logic             done_out,
	output logic [15:0]      rd_data_out,
	output logic             irq_out
);
	// Strobe outlasts both pin synchronisers, so read data is settled at capture
	localparam logic [2:0] PHASE_CYCLES = `DHP_PHASE_CYCLES;

	dhp_pkg::dhp_host_state_t state;
	logic [2:0]  cnt;
	logic        is_write;
	logic [15:0] data_s;
	logic        irq_s;

	dhp_sync #(.WIDTH(17)) u_sync_in (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.async_in ({bus.new_output_irq, bus.data_bus}),
		.sync_out ({irq_s, data_s})
	);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state              <= dhp_pkg::DHP_HOST_IDLE;
			cnt                <= 3'h0;
			is_write           <= 1'b0;
			busy_out           <= 1'b0;
			done_out           <= 1'b0;
			rd_data_out        <= 16'h0000;
			irq_out            <= 1'b0;
			bus.addr           <= 3'h0;
			bus.chip_sel_n     <= 1'b1;
			bus.wr_strobe_n    <= 1'b1;
			bus.rd_strobe_n    <= 1'b1;
			bus.bus_mode       <= 1'b0;
			bus.data_from_host <= 16'h0000;
			bus.data_host_oe_n <= 1'b1;
		end else if (ce_in) begin
			done_out <= 1'b0;
			irq_out  <= irq_s;
			case (state)
				dhp_pkg::DHP_HOST_IDLE: begin
					bus.bus_mode <= mode_in;
					if (req_in) begin
						is_write           <= req_write_in;
						busy_out           <= 1'b1;
						// Top line reserved: always zero; select timed with address
						bus.addr           <= {1'b0, req_addr_in};
						bus.chip_sel_n     <= 1'b0;
						bus.rd_strobe_n    <= mode_in ? !req_write_in : 1'b1;
						bus.data_from_host <= req_data_in;
						bus.data_host_oe_n <= !req_write_in;
						cnt                <= PHASE_CYCLES;
						state              <= dhp_pkg::DHP_HOST_SETUP;
					end
				end
				dhp_pkg::DHP_HOST_SETUP: begin
					if (cnt == 3'h0) begin
						bus.wr_strobe_n <= bus.bus_mode ? 1'b0 : !is_write;
						bus.rd_strobe_n <= bus.bus_mode ? bus.rd_strobe_n : is_write;
						cnt             <= PHASE_CYCLES;
						state           <= dhp_pkg::DHP_HOST_STROBE;
					end else begin
						cnt <= cnt - 3'h1;
					end
				end
				dhp_pkg::DHP_HOST_STROBE: begin
					if (cnt == 3'h0) begin
						rd_data_out     <= data_s;
						bus.wr_strobe_n <= 1'b1;
						if (!bus.bus_mode) begin
							bus.rd_strobe_n <= 1'b1;
						end
						cnt             <= PHASE_CYCLES;
						state           <= dhp_pkg::DHP_HOST_RELEASE;
					end else begin
						cnt <= cnt - 3'h1;
					end
				end
				dhp_pkg::DHP_HOST_RELEASE: begin
					if (cnt == 3'h0) begin
						bus.chip_sel_n     <= 1'b1;
						bus.rd_strobe_n    <= 1'b1;
						bus.data_host_oe_n <= 1'b1;
						busy_out           <= 1'b0;
						done_out           <= 1'b1;
						state              <= dhp_pkg::DHP_HOST_IDLE;
					end else begin
						cnt <= cnt - 3'h1;
					end
				end
				default: begin
					state <= dhp_pkg::DHP_HOST_IDLE;
				end
			endcase
		end
	end
endmodule // dhp_host

//--- test/dhp_sva.sv
`timescale 1ns/10ps
module dhp_sva (
	input  wire logic       mclk_in,
	input  wire logic       rst_n_in,
	input  wire logic       data_dev_oe_n,
	input  wire logic       data_host_oe_n,
	input  wire logic [2:0] addr,
	input  wire logic       chip_sel_n,
	input  wire logic       wr_strobe_n,
	input  wire logic       rd_strobe_n,
	input  wire logic       bus_mode
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	wire rd_mode0 = !bus_mode && !rd_strobe_n && !chip_sel_n;
	wire rd_mode1 = bus_mode && !wr_strobe_n && rd_strobe_n;
	wire wr_phase = bus_mode ? !rd_strobe_n : !chip_sel_n;
	sequence s_rd0;
		rd_mode0[*4];
	endsequence
	sequence s_rd1;
		rd_mode1[*4];
	endsequence
	sequence s_idle;
		(!rd_mode0 && !rd_mode1)[*4];
	endsequence
	// =====
	// Bus ownership and strobes
	a_no_bus_fight: assert property (!(!data_dev_oe_n && !data_host_oe_n)) else $error("bus driven twice");
	a_read_drive0: assert property (s_rd0 |-> !data_dev_oe_n) else $error("mode0 read not driven");
	a_read_drive1: assert property (s_rd1 |-> !data_dev_oe_n) else $error("mode1 read not driven");
	a_bus_release: assert property (s_idle |-> data_dev_oe_n) else $error("bus not released");
	a_addr_top: assert property (addr[2] == 1'b0) else $error("top address line set");
	a_cs_strobe: assert property ((!bus_mode && (!wr_strobe_n || !rd_strobe_n)) |-> !chip_sel_n)
		else $error("strobe without select");
	a_strobe_width: assert property ($fell(wr_strobe_n) |=> !wr_strobe_n[*2]) else $error("strobe too short");
	a_write_edge: assert property (($rose(wr_strobe_n) && wr_phase) |-> (!data_host_oe_n && $stable(addr)))
		else $error("write edge without data");
	a_dir_stable: assert property ((bus_mode && !wr_strobe_n) |=> (wr_strobe_n || $stable(rd_strobe_n)))
		else $error("direction moved in strobe");
endmodule // dhp_sva

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
	logic        mclk_in;
	logic        rst_n_in;
	logic        mode_in;
	logic        req_in;
	logic        req_write_in;
	logic [1:0]  req_addr_in;
	logic [15:0] req_data_in;
	logic        done_out;
	logic        busy;
	logic        host_irq;
	logic [15:0] rd_data_out;
	logic [15:0] chan_data_in;
	logic        chan_valid_in;
	logic [15:0] tgt [4];
	logic [15:0] q;
	int          mismatches;
	int          comparisons;
	dhp_bus_if bus ();
	dhp_device i_dhp_device (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .bus(bus.dev),
		.chan_data_in(chan_data_in), .chan_valid_in(chan_valid_in), .target0_out(tgt[0]),
		.target1_out(tgt[1]), .target2_out(tgt[2]), .target3_out(tgt[3]));
	dhp_host i_dhp_host (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .bus(bus.host),
		.mode_in(mode_in), .req_in(req_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
		.req_data_in(req_data_in), .busy_out(busy), .done_out(done_out), .rd_data_out(rd_data_out),
		.irq_out(host_irq));
	dhp_sva i_dhp_sva (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .data_dev_oe_n(bus.data_dev_oe_n),
		.data_host_oe_n(bus.data_host_oe_n), .addr(bus.addr), .chip_sel_n(bus.chip_sel_n),
		.wr_strobe_n(bus.wr_strobe_n), .rd_strobe_n(bus.rd_strobe_n), .bus_mode(bus.bus_mode));
	// =====
	// Shared tasks
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic xfer(input logic m, input logic w, input logic [1:0] a, input logic [15:0] d);
		int n;
		mode_in = m;
		req_write_in = w;
		req_addr_in = a;
		req_data_in = d;
		req_in = 1'b1;
		@(negedge mclk_in);
		req_in = 1'b0;
		check("select busy", {14'h0000, busy, bus.chip_sel_n}, 16'h0002);
		for (n = 0; n < 100 && done_out !== 1'b1; n++)
			@(negedge mclk_in);
		if (n == 100) begin
			mismatches++;
			stop_test();
		end
		q = rd_data_out;
		@(negedge mclk_in);
	endtask
	// =====
	// Scenarios
	task automatic t_mode0;
		xfer(1'b0, 1'b1, 2'h0, 16'h00A5);
		xfer(1'b0, 1'b1, 2'h1, 16'h0002);
		check("target2", tgt[2], 16'h00A5);
		xfer(1'b0, 1'b0, 2'h0, 16'h0000);
		check("hold read", q, 16'h00A5);
		xfer(1'b0, 1'b0, 2'h1, 16'h0000);
		check("target1 read", q, 16'h0000);
		$display("test mode0 done");
	endtask
	task automatic t_mode1;
		xfer(1'b1, 1'b1, 2'h0, 16'h1234);
		xfer(1'b1, 1'b1, 2'h1, 16'h0003);
		check("target3", tgt[3], 16'h1234);
		check("target2 kept", tgt[2], 16'h00A5);
		xfer(1'b1, 1'b1, 2'h3, 16'hFFFF);
		xfer(1'b1, 1'b0, 2'h0, 16'h0000);
		check("mode1 read", q, 16'h1234);
		$display("test mode1 done");
	endtask
	task automatic t_irq;
		logic [15:0] cnt;
		logic [15:0] hcnt;
		xfer(1'b0, 1'b1, 2'h0, 16'h0003);
		xfer(1'b0, 1'b1, 2'h1, 16'h0000);
		check("irq length reg", tgt[0], 16'h0003);
		chan_data_in = 16'hBEEF;
		chan_valid_in = 1'b1;
		@(negedge mclk_in);
		chan_valid_in = 1'b0;
		cnt = 16'h0000;
		hcnt = 16'h0000;
		repeat (12) begin
			if (bus.new_output_irq === 1'b1)
				cnt++;
			if (host_irq === 1'b1)
				hcnt++;
			@(negedge mclk_in);
		end
		check("irq cycles", cnt, 16'h0003);
		check("host irq cycles", hcnt, 16'h0003);
		xfer(1'b0, 1'b0, 2'h2, 16'h0000);
		check("status set", {15'h0000, q[0]}, 16'h0001);
		xfer(1'b0, 1'b0, 2'h3, 16'h0000);
		check("channel word", q, 16'hBEEF);
		xfer(1'b0, 1'b0, 2'h2, 16'h0000);
		check("status clear", {15'h0000, q[0]}, 16'h0000);
		$display("test irq done");
	endtask
	// =====
	// Clock and main sequence
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end
	initial begin
		rst_n_in = 1'b0;
		mode_in = 1'b0;
		req_in = 1'b0;
		req_write_in = 1'b0;
		req_addr_in = 2'h0;
		req_data_in = 16'h0000;
		chan_data_in = 16'h0000;
		chan_valid_in = 1'b0;
		mismatches = 0;
		comparisons = 0;
		repeat (10) @(negedge mclk_in);
		rst_n_in = 1'b1;
		@(negedge mclk_in);
		t_mode0();
		t_mode1();
		t_irq();
		stop_test();
	end
endmodule // tb
